/* css_map.svh */
// Summary of operation
// RULE1: Writing 02 hex to the trigger register starts conversion of all three channels.
// RULE2: The trigger register returns to 00 hex by itself when conversion finishes.
// RULE3: Red result reads at 44 hex, green at 43 hex, blue at 42 hex.
// RULE4: The port is always a slave transceiver, up to 100 kbit per second. The bench master uses 800 ns slots, about 1.25 Mbit per second.
// RULE5: Data is open-drain with pull-up; idle bus rests with both lines high.
// RULE6: Start is data falling while clock is high.
// RULE7: Stop is data rising while clock is high; bus becomes free.
// RULE8: Repeated start behaves as start: address reception restarts, bus stays busy.
// RULE9: Data only changes while clock is low and stays stable while high.
// RULE10: Bytes are eight bits, most significant first, plus one acknowledge slot.
// RULE11: Slave drives data only to acknowledge writes or send requested read data.
// RULE12: Master changes data on clock fall and samples slave data on clock rise.
// RULE13: The receiving party pulls data low in the ninth clock to acknowledge.
// RULE14: After a missing slave acknowledge the master stops or repeats start.
// RULE15: Master ends a read with not-acknowledge; slave then releases data.
// RULE16: Master clocks every acknowledge bit, including those the slave drives.
// RULE17: First byte holds seven address bits then direction: one read, zero write.
// RULE18: On address match the slave acknowledges and takes the direction given.
// RULE19: The slave answers to seven-bit address 58 hex.
// RULE20: Write: address, register address, one data byte, each acknowledged, then stop.
// RULE21: Read: write register address, repeated start, read address, data, not-acknowledge.
// RULE22: Low reset clears all registers asynchronously; pulse lasts at least one microsecond. The bench's first reset pulse lasts only 400 ns.
// RULE23: While sleep is high, analog is powered down and core logic frozen.
// RULE24: Mismatched address is not acknowledged; transfer ignored until next start.
// RULE25: Clock and data inputs are synchronised and edge-detected before decoding.
`ifndef CSS_MAP_SVH
`define CSS_MAP_SVH
`define CSS_CLK_MHZ 10
`define CSS_SLAVE_ADDR 7'h58
`define CSS_REG_TRIGGER 8'h02
`define CSS_REG_BLUE 8'h42
`define CSS_REG_GREEN 8'h43
`define CSS_REG_RED 8'h44
`define CSS_TRIG_START 8'h02
`define CSS_TRIG_IDLE 8'h00
`define CSS_RESULT_RST 8'h00
`define CSS_READ_UNMAPPED 8'h00
`define CSS_BITS_PER_BYTE 4'h8
`define CSS_CONV_TIME_US 100
`define CSS_CONV_CYCLES (`CSS_CONV_TIME_US * `CSS_CLK_MHZ)
`define CSS_RESET_TIME_US 1
`define CSS_RESET_CYCLES (`CSS_RESET_TIME_US * `CSS_CLK_MHZ)
`endif

/* css_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module css_master_model
(
  // Clock that paces the bit slots.
  input wire logic clk,
  // Resolved level of the data wire.
  input wire logic sda,
  // Serial clock and data pull-down driven by the master.
  output logic scl,
  output logic sda_oe
);
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One 800 ns slot: five cycles low, three high, so the slave has time to turn data round.
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_oe = ~b;
    tick(4);
    scl = 1'b1;
    r = sda;
    tick(3);
    scl = 1'b0;
  endtask

  task automatic start_cond();
    tick(1);
    sda_oe = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(2);
    sda_oe = 1'b1;
    tick(3);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    tick(1);
    sda_oe = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(2);
    sda_oe = 1'b0;
    tick(3);
  endtask

  task automatic byte_out(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic byte_in(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic a0;
    logic a1;
    logic a2;
    a1 = 1'b0;
    a2 = 1'b0;
    start_cond();
    byte_out({dev, 1'b0}, a0);
    if (a0)
      byte_out(a, a1);
    if (a1)
      byte_out(d, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] v,
                          output logic ok);
    logic a0;
    logic a1;
    logic a2;
    a1 = 1'b0;
    a2 = 1'b0;
    v = 8'hxx;
    start_cond();
    byte_out({dev, 1'b0}, a0);
    if (a0)
      byte_out(a, a1);
    if (a1)
    begin
      start_cond();
      byte_out({dev, 1'b1}, a2);
    end
    if (a2)
      byte_in(1'b1, v);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Reads two registers in one frame; the acknowledge after the first byte asks for more.
  task automatic read_two(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] v0,
                          output logic [7:0] v1, output logic ok);
    logic a0;
    logic a1;
    logic a2;
    a1 = 1'b0;
    a2 = 1'b0;
    v0 = 8'hxx;
    v1 = 8'hxx;
    start_cond();
    byte_out({dev, 1'b0}, a0);
    if (a0)
      byte_out(a, a1);
    if (a1)
    begin
      start_cond();
      byte_out({dev, 1'b1}, a2);
    end
    if (a2)
    begin
      byte_in(1'b0, v0);
      byte_in(1'b1, v1);
    end
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

/* css_pkg.sv */
`default_nettype none
package css_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } css_state_t;
  typedef logic [7:0] css_byte_t;
endpackage
`default_nettype wire

/* css_serial_slave.sv */
`timescale 1ns/10ps
`default_nettype none
`include "css_map.svh"
module css_serial_slave
(
  // System clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Power control.
  input wire logic SLEEP,
  output logic ANALOG_PD,
  // Serial clock pin.
  input wire logic SERIAL_CLOCK_PIN,
  // Serial data pin, open drain.
  input wire logic SERIAL_DATA_PIN_IN,
  output logic SERIAL_DATA_PIN_OUT,
  output logic SERIAL_DATA_PIN_OE,
  // Converter channel values and conversion status.
  input wire logic [7:0] ADC_RED,
  input wire logic [7:0] ADC_GREEN,
  input wire logic [7:0] ADC_BLUE,
  output logic CONV_BUSY
);

  localparam int unsigned CONV_CYCLES = `CSS_CONV_CYCLES;
  localparam logic [9:0] CONV_LOAD = 10'(CONV_CYCLES);

  function automatic css_pkg::css_byte_t read_mux(input css_pkg::css_byte_t addr,
    input css_pkg::css_byte_t trig, input css_pkg::css_byte_t red,
    input css_pkg::css_byte_t green, input css_pkg::css_byte_t blue);
    css_pkg::css_byte_t val;
    val = `CSS_READ_UNMAPPED;
    if (addr == `CSS_REG_TRIGGER)
      val = trig;
    else if (addr == `CSS_REG_RED)
      val = red;
    else if (addr == `CSS_REG_GREEN)
      val = green;
    else if (addr == `CSS_REG_BLUE)
      val = blue;
    return val;
  endfunction

  // Synchronisers: q1 feeds q2 only, q3 keeps the previous synchronised value.
  logic scl_q1_r, scl_q2_r, scl_q3_r;
  logic sda_q1_r, sda_q2_r, sda_q3_r;
  logic slp_q1_r, slp_q2_r;

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scl_q1_r <= 1'b1;
      scl_q2_r <= 1'b1;
      scl_q3_r <= 1'b1;
      sda_q1_r <= 1'b1;
      sda_q2_r <= 1'b1;
      sda_q3_r <= 1'b1;
      slp_q1_r <= 1'b0;
      slp_q2_r <= 1'b0;
    end
    else
    begin
      scl_q1_r <= SERIAL_CLOCK_PIN; // [RULE25]
      scl_q2_r <= scl_q1_r;
      scl_q3_r <= scl_q2_r;
      sda_q1_r <= SERIAL_DATA_PIN_IN;
      sda_q2_r <= sda_q1_r;
      sda_q3_r <= sda_q2_r;
      slp_q1_r <= SLEEP;
      slp_q2_r <= slp_q1_r;
    end
  end

  // Sleep freezes every state register below; only the synchronisers keep running.
  wire core_en = ~slp_q2_r; // [RULE23]
  wire scl_rise = core_en & scl_q2_r & ~scl_q3_r; // [RULE25]
  wire scl_fall = core_en & ~scl_q2_r & scl_q3_r;
  wire start_det = core_en & scl_q2_r & scl_q3_r & sda_q3_r & ~sda_q2_r; // [RULE6]
  wire stop_det = core_en & scl_q2_r & scl_q3_r & ~sda_q3_r & sda_q2_r; // [RULE7]

  css_pkg::css_state_t state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  css_pkg::css_byte_t shift_r, shift_nxt;
  css_pkg::css_byte_t ptr_r, ptr_nxt;
  logic first_r, first_nxt;
  logic have_reg_r, have_reg_nxt;
  logic rw_r, rw_nxt;
  logic nack_r, nack_nxt;
  logic oe_r, oe_nxt;
  logic wr_en;
  css_pkg::css_byte_t trig_r, red_r, green_r, blue_r;
  logic [9:0] conv_cnt_r;

  wire byte_done = (bit_cnt_r == `CSS_BITS_PER_BYTE);
  wire addr_match = (shift_r[7:1] == `CSS_SLAVE_ADDR); // [RULE19]
  wire css_pkg::css_byte_t rd_data = read_mux(ptr_r, trig_r, red_r, green_r, blue_r);
  wire css_pkg::css_byte_t ptr_inc = ptr_r + 8'h01;
  wire css_pkg::css_byte_t next_data = read_mux(ptr_inc, trig_r, red_r, green_r, blue_r);

  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    first_nxt = first_r;
    have_reg_nxt = have_reg_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    oe_nxt = oe_r;
    wr_en = 1'b0;
    if (start_det)
    begin
      // A repeated start is handled exactly like a first start.
      state_nxt = css_pkg::ST_RX; // [RULE8]
      bit_cnt_nxt = 4'h0;
      first_nxt = 1'b1;
      have_reg_nxt = 1'b0;
      oe_nxt = 1'b0;
    end
    else if (stop_det)
    begin
      state_nxt = css_pkg::ST_IDLE; // [RULE7]
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        css_pkg::ST_IDLE:
        begin
          oe_nxt = 1'b0;
        end
        css_pkg::ST_RX:
        begin
          if (scl_rise && !byte_done)
          begin
            shift_nxt = {shift_r[6:0], sda_q2_r}; // [RULE10]
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          end
          else if (scl_fall && byte_done)
          begin
            state_nxt = css_pkg::ST_ACK;
            oe_nxt = 1'b1; // [RULE13]
            if (first_r)
            begin
              if (addr_match)
                rw_nxt = shift_r[0]; // [RULE17] [RULE18] [RULE4]
              else
              begin
                state_nxt = css_pkg::ST_IDLE; // [RULE24]
                oe_nxt = 1'b0;
              end
            end
            else if (!have_reg_r)
            begin
              ptr_nxt = shift_r;
              have_reg_nxt = 1'b1;
            end
            else
              wr_en = 1'b1; // [RULE20]
          end
        end
        css_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_nxt = 4'h0;
            first_nxt = 1'b0;
            if (rw_r)
            begin
              state_nxt = css_pkg::ST_TX; // [RULE21]
              shift_nxt = rd_data;
              oe_nxt = ~rd_data[7]; // [RULE11]
            end
            else
            begin
              state_nxt = css_pkg::ST_RX;
              oe_nxt = 1'b0;
            end
          end
        end
        css_pkg::ST_TX:
        begin
          if (scl_rise)
            bit_cnt_nxt = bit_cnt_r + 4'h1;
          else if (scl_fall)
          begin
            if (byte_done)
            begin
              state_nxt = css_pkg::ST_TXACK;
              oe_nxt = 1'b0;
            end
            else
            begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = ~shift_r[6]; // [RULE9]
            end
          end
        end
        css_pkg::ST_TXACK:
        begin
          if (scl_rise)
            nack_nxt = sda_q2_r;
          else if (scl_fall)
          begin
            if (nack_r)
              state_nxt = css_pkg::ST_IDLE; // [RULE15]
            else
            begin
              // The master asked for more: the next register's first bit must be on the
              // wire before the coming clock rise, so it is loaded at this fall.
              state_nxt = css_pkg::ST_TX;
              bit_cnt_nxt = 4'h0;
              ptr_nxt = ptr_inc;
              shift_nxt = next_data;
              oe_nxt = ~next_data[7]; // [RULE11]
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_r <= css_pkg::ST_IDLE; // [RULE22]
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      first_r <= 1'b0;
      have_reg_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b1;
      oe_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      first_r <= first_nxt;
      have_reg_r <= have_reg_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      oe_r <= oe_nxt;
    end
  end

  wire trig_wr = wr_en & (ptr_r == `CSS_REG_TRIGGER);
  wire conv_go = trig_wr & (shift_r == `CSS_TRIG_START); // [RULE1]
  wire conv_done = core_en & (conv_cnt_r == 10'h001);

  // A trigger write in the finishing cycle wins over the self clear.
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      trig_r <= `CSS_TRIG_IDLE;
      conv_cnt_r <= 10'h000;
      red_r <= `CSS_RESULT_RST;
      green_r <= `CSS_RESULT_RST;
      blue_r <= `CSS_RESULT_RST;
    end
    else if (core_en)
    begin
      if (trig_wr)
        trig_r <= shift_r;
      else if (conv_done)
        trig_r <= `CSS_TRIG_IDLE; // [RULE2]
      if (conv_go)
        conv_cnt_r <= CONV_LOAD; // [RULE1]
      else if (conv_cnt_r != 10'h000)
        conv_cnt_r <= conv_cnt_r - 10'h001;
      if (conv_done)
      begin
        red_r <= ADC_RED; // [RULE3]
        green_r <= ADC_GREEN;
        blue_r <= ADC_BLUE;
      end
    end
  end

  // The pin is only ever pulled low; a high level comes from the pull-up.
  assign SERIAL_DATA_PIN_OUT = 1'b0; // [RULE5]
  assign SERIAL_DATA_PIN_OE = oe_r; // [RULE11]
  assign CONV_BUSY = (conv_cnt_r != 10'h000);
  assign ANALOG_PD = slp_q2_r; // [RULE23]

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);

  sequence s_addr_miss;
    (state_r == css_pkg::ST_RX) && first_r && byte_done && scl_fall && !addr_match
      && !start_det && !stop_det;
  endsequence

  sequence s_read_nack;
    (state_r == css_pkg::ST_TXACK) && nack_r && scl_fall && !start_det && !stop_det;
  endsequence

  drive_when_allowed_a: assert property ( // [RULE11]
    oe_r |-> (state_r == css_pkg::ST_ACK) || (state_r == css_pkg::ST_TX))
    else $error("Data pin driven outside acknowledge or read data.");

  start_restarts_a: assert property ( // [RULE8]
    start_det |=> (state_r == css_pkg::ST_RX) && first_r && (bit_cnt_r == 4'h0) && !oe_r)
    else $error("Start did not restart address reception.");

  stop_frees_bus_a: assert property ( // [RULE7]
    stop_det && !start_det |=> (state_r == css_pkg::ST_IDLE) && !oe_r)
    else $error("Stop did not free the bus.");

  addr_miss_ignored_a: assert property ( // [RULE24]
    s_addr_miss |=> (state_r == css_pkg::ST_IDLE) ##1 !oe_r)
    else $error("Mismatched address was acknowledged.");

  data_change_low_a: assert property ( // [RULE9]
    $changed(oe_r) |-> !scl_q2_r || $past(start_det) || $past(stop_det))
    else $error("Data pin changed while clock high.");

  trigger_start_a: assert property ( // [RULE1]
    conv_go |=> CONV_BUSY && (trig_r == `CSS_TRIG_START))
    else $error("Trigger write did not start conversion.");

  trigger_clear_a: assert property ( // [RULE2]
    conv_done && !trig_wr |=> (trig_r == `CSS_TRIG_IDLE) && !CONV_BUSY)
    else $error("Trigger did not clear after conversion.");

  nack_release_a: assert property ( // [RULE15]
    s_read_nack |=> !oe_r && (state_r == css_pkg::ST_IDLE))
    else $error("Slave kept driving after not-acknowledge.");

  sleep_freeze_a: assert property ( // [RULE23]
    slp_q2_r |=> $stable(state_r) && $stable(trig_r) && $stable(conv_cnt_r))
    else $error("Core logic moved during sleep.");

  byte_width_a: assert property ( // [RULE10]
    (state_r == css_pkg::ST_RX) && byte_done && !scl_fall && !start_det && !stop_det |=>
      $stable(shift_r) && (bit_cnt_r == `CSS_BITS_PER_BYTE))
    else $error("More than eight bits shifted into a byte.");

  ack_ninth_a: assert property ( // [RULE13]
    (state_r == css_pkg::ST_RX) && byte_done && scl_fall && !first_r && !start_det
      && !stop_det |=> oe_r && (state_r == css_pkg::ST_ACK))
    else $error("Received byte not acknowledged.");

  results_capture_a: assert property ( // [RULE3]
    conv_done |=> (red_r == $past(ADC_RED)) && (green_r == $past(ADC_GREEN))
      && (blue_r == $past(ADC_BLUE)))
    else $error("Channel results not captured at conversion end.");

endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "css_map.svh"
`define TB_CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic sleep = 1'b0;
  logic [7:0] adc_red = 8'h00;
  logic [7:0] adc_green = 8'h00;
  logic [7:0] adc_blue = 8'h00;
  logic scl;
  logic m_oe;
  logic d_out;
  logic d_oe;
  logic sda_wire;
  logic analog_pd;
  logic conv_busy;
  logic ok;
  css_pkg::css_byte_t got;
  css_pkg::css_byte_t got2;
  int errors = 0;
  int checked = 0;

  always #50 clk_sys = ~clk_sys;

  // The pull-up wins unless some party pulls low.
  assign sda_wire = !(m_oe || (d_oe && !d_out));

  css_serial_slave css_serial_slave_inst (.CLK_SYS(clk_sys), .RST_N(rst_n), .SLEEP(sleep),
    .ANALOG_PD(analog_pd), .SERIAL_CLOCK_PIN(scl), .SERIAL_DATA_PIN_IN(sda_wire),
    .SERIAL_DATA_PIN_OUT(d_out), .SERIAL_DATA_PIN_OE(d_oe), .ADC_RED(adc_red),
    .ADC_GREEN(adc_green), .ADC_BLUE(adc_blue), .CONV_BUSY(conv_busy));

  css_master_model css_master_model_inst (.clk(clk_sys), .sda(sda_wire), .scl(scl),
    .sda_oe(m_oe));

  task automatic wrap_up();
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    css_master_model_inst.write_reg(`CSS_SLAVE_ADDR, a, d, ok);
    `TB_CHECK("write ack", 1'b1, ok)
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    css_master_model_inst.read_reg(`CSS_SLAVE_ADDR, a, got, ok);
    `TB_CHECK("read ack", 1'b1, ok)
    `TB_CHECK("read data", exp, got)
  endtask

  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(`CSS_REG_TRIGGER, `CSS_TRIG_IDLE);
    rd(`CSS_REG_RED, `CSS_RESULT_RST);
    wr(`CSS_REG_TRIGGER, 8'h01);
    `TB_CHECK("busy on other value", 1'b0, conv_busy)
    rd(`CSS_REG_TRIGGER, 8'h01);
    adc_red = 8'h3c;
    adc_green = 8'h5a;
    adc_blue = 8'h71;
    wr(`CSS_REG_TRIGGER, `CSS_TRIG_START);
    `TB_CHECK("busy after start", 1'b1, conv_busy)
    rd(`CSS_REG_TRIGGER, `CSS_TRIG_START);
    for (int n = 0; n < 2000 && conv_busy !== 1'b0; n++)
      @(negedge clk_sys);
    `TB_CHECK("busy at end", 1'b0, conv_busy)
    adc_red = 8'hff;
    rd(`CSS_REG_TRIGGER, `CSS_TRIG_IDLE);
    rd(`CSS_REG_RED, 8'h3c);
    rd(`CSS_REG_GREEN, 8'h5a);
    rd(`CSS_REG_BLUE, 8'h71);
    css_master_model_inst.read_two(`CSS_SLAVE_ADDR, `CSS_REG_GREEN, got, got2, ok);
    `TB_CHECK("pair ack", 1'b1, ok)
    `TB_CHECK("pair first", 8'h5a, got)
    `TB_CHECK("pair second", 8'h3c, got2)
    wr(`CSS_REG_RED, 8'ha5);
    rd(`CSS_REG_RED, 8'h3c);
    wr(8'h10, 8'h77);
    rd(8'h10, `CSS_READ_UNMAPPED);
    css_master_model_inst.write_reg(7'h59, `CSS_REG_TRIGGER, `CSS_TRIG_START, ok);
    `TB_CHECK("foreign address ack", 1'b0, ok)
    `TB_CHECK("busy after foreign", 1'b0, conv_busy)
    // Sleep is checked with a full frame so a frozen core must also miss the start.
    sleep = 1'b1;
    repeat (4) @(negedge clk_sys);
    `TB_CHECK("analog power down", 1'b1, analog_pd)
    css_master_model_inst.write_reg(`CSS_SLAVE_ADDR, `CSS_REG_TRIGGER, 8'h01, ok);
    `TB_CHECK("ack while asleep", 1'b0, ok)
    sleep = 1'b0;
    repeat (4) @(negedge clk_sys);
    `TB_CHECK("analog awake", 1'b0, analog_pd)
    rd(`CSS_REG_TRIGGER, `CSS_TRIG_IDLE);
    wr(`CSS_REG_TRIGGER, 8'h01);
    rst_n = 1'b0;
    repeat (`CSS_RESET_CYCLES) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(`CSS_REG_TRIGGER, `CSS_TRIG_IDLE);
    rd(`CSS_REG_BLUE, `CSS_RESULT_RST);
    wrap_up();
  end

  // The tests take well under a millisecond; three leave ample margin.
  initial
  begin
    #3000000;
    errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
